// *** design/enc_defines.vh ***
// Constants for the error notification and capture block
// How it works
// - Machine check vector 04 for synchronous faults
// - Soft error interrupt vector 54 classes
// - Hard error interrupt vector 60 classes
// - Console halt jumps to halt target register
// - Severity: halt, check, hard, soft
// - Machine check synchronous with instruction stream
// - Hard error interrupt asynchronous, data lost
// - Soft error interrupt asynchronous, not fatal
// - Error interrupt level, external or status
// - Status error bits are write-one-to-clear
// - Second error sets overflow, context kept
// - Machine check frame gets PC, PSL, info
// - Tag capture on tag or fill errors
// - Bus error address on probe/bus errors
// - Fill address and syndrome on fill errors
// - Every read-returned quadword counts as fill
// - One dirty bit per cache block
// - Read tag parity: soft, arbiter error state
`ifndef ENC_DEFINES_VH
`define ENC_DEFINES_VH

`define ENC_ADDR_STATUS    4'h0
`define ENC_ADDR_BUS_ADDR  4'h1
`define ENC_ADDR_FILL_ADDR 4'h2
`define ENC_ADDR_SYNDROME  4'h3
`define ENC_ADDR_TAG       4'h4
`define ENC_ADDR_HALT_TGT  4'h5
`define ENC_ADDR_DIRTY_IX  4'h6
`define ENC_ADDR_DIRTY     4'h7

// Status bit positions
`define ENC_ST_BUS_HARD    0
`define ENC_ST_BUS_SOFT    1
`define ENC_ST_TAG_PAR     2
`define ENC_ST_TAGCTL_PAR  3
`define ENC_ST_ACK_HARD    4
`define ENC_ST_FILL_ECC    5
`define ENC_ST_FILL_PAR    6
`define ENC_ST_OVERFLOW    7
`define ENC_ST_WIDTH       8

`define ENC_VEC_MCHK       8'h04
`define ENC_VEC_SOFT       8'h54
`define ENC_VEC_HARD       8'h60
`define ENC_VEC_NONE       8'h00

`define ENC_HALT_TGT_RESET 32'h00000000

`endif

// *** design/enc_dirty_mem.v ***
// Dirty bit store, one bit per cache block
`timescale 1ns/1ps
module enc_dirty_mem #(
    parameter AW = 8
) (
    input  wire          core_clk_in,   // Clock
    input  wire          rst_in,        // Async reset
    input  wire          wr_en_in,      // Write enable
    input  wire [AW-1:0] wr_idx_in,     // Write block index
    input  wire          wr_bit_in,     // Dirty value
    input  wire [AW-1:0] rd_idx_in,     // Read block index
    output reg           rd_bit_out     // Registered read data
);
    reg [(1<<AW)-1:0] bits;

    always @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bits       <= {(1<<AW){1'b0}};
            rd_bit_out <= 1'b0;
        end
        else
        begin
            if (wr_en_in)
                bits[wr_idx_in] <= wr_bit_in;
            rd_bit_out <= bits[rd_idx_in];
        end
    end
endmodule // enc_dirty_mem

// *** design/enc_error_unit.v ***
// Error notification routing and capture registers
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "enc_defines.vh"
module enc_error_unit #(
    parameter AW  = 32,
    parameter SW  = 8,
    parameter TW  = 20,
    parameter DIW = 8
) (
    input  wire           core_clk_in,        // 10 MHz clock
    input  wire           rst_in,             // Async reset, high
    input  wire [3:0]     reg_addr_in,        // Register index
    input  wire [31:0]    reg_wdata_in,       // Write data
    input  wire           reg_wr_in,          // Write strobe
    input  wire           reg_rd_in,          // Read strobe
    output reg  [31:0]    reg_rdata_out,      // Read data, next cycle
    input  wire           halt_err_in,        // Console-halt error event
    input  wire           mmgt_fault_in,      // Memory management fault
    input  wire           ucode_fault_in,     // Microcode-detected fault
    input  wire           stall_timeout_in,   // Stall timeout
    input  wire           tb_parity_in,       // Translation buffer parity
    input  wire           icache_parity_in,   // Instruction cache parity
    input  wire           pcache_parity_in,   // Primary cache parity
    input  wire           op_write_in,        // Current op is a write
    input  wire           tag_parity_error_in,        // Tag parity
    input  wire           tag_control_parity_error_in, // Tag control parity
    input  wire           ack_hard_error_in,  // Hard error acknowledge
    input  wire           bus_soft_error_in,  // Bus soft error
    input  wire           bus_hard_error_in,  // Bus hard error
    input  wire           fill_valid_in,      // Quadword returned on read
    input  wire           fill_ecc_ue_in,     // Uncorrectable fill data
    input  wire           fill_ecc_ce_in,     // Correctable fill data
    input  wire           fill_parity_error_in, // Fill parity error
    input  wire [AW-1:0]  access_addr_in,     // Probe/bus address
    input  wire [AW-1:0]  fill_addr_in,       // Fill address
    input  wire [SW-1:0]  fill_syndrome_in,   // Fill check syndrome
    input  wire [TW-1:0]  cache_tag_in,       // Tag read on lookup
    input  wire [31:0]    cur_pc_in,          // Current instruction PC
    input  wire [31:0]    cur_psl_in,         // Current status word
    input  wire           instr_boundary_in,  // Instruction retire point
    input  wire           ext_error_in,       // External error pin
    input  wire           dirty_wr_in,        // Dirty bit write
    input  wire [DIW-1:0] dirty_idx_in,       // Dirty bit block index
    input  wire           dirty_val_in,       // Dirty bit value
    output reg            halt_req_out,       // Console halt request
    output reg  [31:0]    halt_pc_out,        // Halt target address
    output reg            mchk_out,           // Machine check pulse
    output reg  [7:0]     vector_out,         // Vector index of event
    output reg  [31:0]    frame_pc_out,       // Frame PC
    output reg  [31:0]    frame_psl_out,      // Frame status word
    output reg  [31:0]    frame_info_out,     // Frame error info
    output reg            hard_int_out,       // Hard error interrupt level
    output reg            soft_int_out,       // Soft error interrupt level
    output reg            arb_error_out,      // Arbiter to error state
    output reg            fill_hard_err_out   // Hard error with fill done
);
    // Synchroniser for the external error pin
    reg ext_s1, ext_s2, ext_s3, ext_level;
    always @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ext_s1    <= 1'b0;
            ext_s2    <= 1'b0;
            ext_s3    <= 1'b0;
            ext_level <= 1'b0;
        end
        else
        begin
            ext_s1 <= ext_error_in;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            if (ext_s2 == ext_s3)
                ext_level <= ext_s3;
        end
    end

    wire rd_op      = ~op_write_in;
    wire tag_any    = tag_parity_error_in | tag_control_parity_error_in;
    wire fill_ev    = fill_valid_in & rd_op;
    wire fill_ue    = fill_ev & fill_ecc_ue_in;
    wire fill_ce    = fill_ev & fill_ecc_ce_in;
    wire fill_par   = fill_ev & fill_parity_error_in;
    wire wr_ue      = fill_valid_in & op_write_in & fill_ecc_ue_in;

    // Event classes per notification path
    wire mchk_ev = mmgt_fault_in | ucode_fault_in | stall_timeout_in | tb_parity_in
                 | icache_parity_in | fill_ue | (ack_hard_error_in & rd_op);
    wire soft_ev = icache_parity_in | pcache_parity_in | (tag_any & rd_op)
                 | fill_ue | fill_ce | (bus_soft_error_in & rd_op);
    wire hard_ev = wr_ue | (tag_any & op_write_in)
                 | (ack_hard_error_in & op_write_in) | bus_hard_error_in;

    // Status events captured in the bus and fill status register
    wire [`ENC_ST_WIDTH-2:0] st_ev;
    assign st_ev[`ENC_ST_BUS_HARD]   = bus_hard_error_in;
    assign st_ev[`ENC_ST_BUS_SOFT]   = bus_soft_error_in;
    assign st_ev[`ENC_ST_TAG_PAR]    = tag_parity_error_in;
    assign st_ev[`ENC_ST_TAGCTL_PAR] = tag_control_parity_error_in;
    assign st_ev[`ENC_ST_ACK_HARD]   = ack_hard_error_in;
    assign st_ev[`ENC_ST_FILL_ECC]   = fill_ue | fill_ce;
    assign st_ev[`ENC_ST_FILL_PAR]   = fill_par;

    reg  [`ENC_ST_WIDTH-1:0] status;
    reg  [AW-1:0] bus_error_address;
    reg  [AW-1:0] fill_error_address;
    reg  [SW-1:0] fill_syndrome;
    reg  [TW-1:0] cache_tag_capture;
    reg  [31:0]   halt_target;
    reg  [DIW-1:0] dirty_rd_idx;
    reg           soft_pend, hard_pend, mchk_pend;
    reg  [31:0]   mchk_info;

    wire any_ev     = |st_ev;
    wire st_busy    = |status[`ENC_ST_WIDTH-2:0];
    wire bus_ev     = bus_hard_error_in | bus_soft_error_in | tag_any;
    wire fillerr_ev = fill_ue | fill_ce | fill_par;
    wire wr_st      = reg_wr_in && reg_addr_in == `ENC_ADDR_STATUS;
    wire [`ENC_ST_WIDTH-1:0] w1c = wr_st ? reg_wdata_in[`ENC_ST_WIDTH-1:0]
                                         : {`ENC_ST_WIDTH{1'b0}};
    wire hard_src = status[`ENC_ST_BUS_HARD] | (status[`ENC_ST_ACK_HARD] & hard_pend);
    wire dirty_rd_bit;

    enc_dirty_mem #(.AW(DIW)) u_dirty (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .wr_en_in    (dirty_wr_in),
        .wr_idx_in   (dirty_idx_in),
        .wr_bit_in   (dirty_val_in),
        .rd_idx_in   (dirty_rd_idx),
        .rd_bit_out  (dirty_rd_bit)
    );

    // Capture registers and status
    always @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            status             <= {`ENC_ST_WIDTH{1'b0}};
            bus_error_address  <= {AW{1'b0}};
            fill_error_address <= {AW{1'b0}};
            fill_syndrome      <= {SW{1'b0}};
            cache_tag_capture  <= {TW{1'b0}};
            halt_target        <= `ENC_HALT_TGT_RESET;
            dirty_rd_idx       <= {DIW{1'b0}};
        end
        else
        begin
            // Overflow set wins over a simultaneous clear; a new event while bits are still set only raises overflow
            // A second error only raises overflow; its own status is dropped
            status[`ENC_ST_WIDTH-2:0] <= (status[`ENC_ST_WIDTH-2:0]
                                          & ~w1c[`ENC_ST_WIDTH-2:0])
                                       | (st_busy ? {(`ENC_ST_WIDTH-1){1'b0}} : st_ev);
            status[`ENC_ST_OVERFLOW]  <= (status[`ENC_ST_OVERFLOW] & ~w1c[`ENC_ST_OVERFLOW])
                                       | (any_ev & st_busy);
            if (!st_busy)
            begin
                if (bus_ev)
                    bus_error_address <= access_addr_in;
                if (fillerr_ev)
                begin
                    fill_error_address <= fill_addr_in;
                    fill_syndrome      <= fill_syndrome_in;
                end
                if (tag_any | fillerr_ev)
                    cache_tag_capture <= cache_tag_in;
            end
            if (reg_wr_in && reg_addr_in == `ENC_ADDR_HALT_TGT)
                halt_target <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == `ENC_ADDR_DIRTY_IX)
                dirty_rd_idx <= reg_wdata_in[DIW-1:0];
        end
    end

    // Notification paths
    always @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            soft_pend         <= 1'b0;
            hard_pend         <= 1'b0;
            mchk_pend         <= 1'b0;
            mchk_info         <= 32'h00000000;
            halt_req_out      <= 1'b0;
            halt_pc_out       <= 32'h00000000;
            mchk_out          <= 1'b0;
            vector_out        <= `ENC_VEC_NONE;
            frame_pc_out      <= 32'h00000000;
            frame_psl_out     <= 32'h00000000;
            frame_info_out    <= 32'h00000000;
            hard_int_out      <= 1'b0;
            soft_int_out      <= 1'b0;
            arb_error_out     <= 1'b0;
            fill_hard_err_out <= 1'b0;
        end
        else
        begin
            // Soft pending clears once software empties the status
            soft_pend <= soft_ev | (soft_pend & st_busy);
            hard_pend <= hard_ev | (hard_pend & st_busy);
            hard_int_out <= hard_ev | ext_level | hard_src;
            soft_int_out <= soft_ev | (soft_pend & st_busy);
            // Read tag parity sends arbiter to error; hard error rides the fill
            arb_error_out <= (tag_any | ack_hard_error_in) & rd_op;
            fill_hard_err_out <= (arb_error_out | fill_ue) & fill_valid_in;
            if (mchk_ev)
                mchk_info <= {24'h000000, status[`ENC_ST_OVERFLOW], st_ev};
            mchk_pend <= (mchk_ev | mchk_pend) & ~instr_boundary_in;
            halt_req_out <= halt_err_in;
            mchk_out     <= 1'b0;
            if (halt_err_in)
            begin
                halt_pc_out <= halt_target;
                vector_out  <= `ENC_VEC_NONE;
            end
            else if ((mchk_pend | mchk_ev) & instr_boundary_in)
            begin
                mchk_out       <= 1'b1;
                vector_out     <= `ENC_VEC_MCHK;
                frame_pc_out   <= cur_pc_in;
                frame_psl_out  <= cur_psl_in;
                frame_info_out <= mchk_ev ? {24'h000000, status[`ENC_ST_OVERFLOW], st_ev}
                                          : mchk_info;
            end
            else if (hard_ev | hard_pend | ext_level)
                vector_out <= `ENC_VEC_HARD;
            else if (soft_ev | soft_pend)
                vector_out <= `ENC_VEC_SOFT;
            else
                vector_out <= `ENC_VEC_NONE;
        end
    end

    // Register read port
    always @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            reg_rdata_out <= 32'h00000000;
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                `ENC_ADDR_STATUS:    reg_rdata_out <= {{(32-`ENC_ST_WIDTH){1'b0}}, status};
                `ENC_ADDR_BUS_ADDR:  reg_rdata_out <= bus_error_address[31:0];
                `ENC_ADDR_FILL_ADDR: reg_rdata_out <= fill_error_address[31:0];
                `ENC_ADDR_SYNDROME:  reg_rdata_out <= {{(32-SW){1'b0}}, fill_syndrome};
                `ENC_ADDR_TAG:       reg_rdata_out <= {{(32-TW){1'b0}}, cache_tag_capture};
                `ENC_ADDR_HALT_TGT:  reg_rdata_out <= halt_target;
                `ENC_ADDR_DIRTY_IX:  reg_rdata_out <= {{(32-DIW){1'b0}}, dirty_rd_idx};
                `ENC_ADDR_DIRTY:     reg_rdata_out <= {31'h00000000, dirty_rd_bit};
                default:             reg_rdata_out <= 32'h00000000;
            endcase
        end
        else
            reg_rdata_out <= 32'h00000000;
    end
endmodule // enc_error_unit

// *** tb/enc_error_unit_chk.sv ***
// Checker for the error notification and capture block
`timescale 1ns/1ps
module enc_error_chk (
    input wire logic        core_clk_in,       // Clock
    input wire logic        rst_in,            // Async reset
    input wire logic        reg_rd_in,         // Read strobe
    input wire logic [31:0] reg_rdata_out,     // Read data
    input wire logic        halt_err_in,       // Halt event
    input wire logic        halt_req_out,      // Halt request
    input wire logic [7:0]  vector_out,        // Vector index
    input wire logic        mmgt_fault_in,     // Memory management fault
    input wire logic        instr_boundary_in, // Retire point
    input wire logic        mchk_out,          // Machine check
    input wire logic [31:0] cur_pc_in,         // Current PC
    input wire logic [31:0] frame_pc_out,      // Frame PC
    input wire logic        op_write_in,       // Write operation
    input wire logic        tag_parity_error_in, // Tag parity
    input wire logic        hard_int_out,      // Hard interrupt
    input wire logic        fill_valid_in,     // Fill quadword
    input wire logic        fill_ecc_ce_in,    // Correctable fill
    input wire logic        soft_int_out,      // Soft interrupt
    input wire logic        bus_hard_error_in, // Bus hard error
    input wire logic        ext_error_in,      // External error pin
    input wire logic        pcache_parity_in   // Primary cache parity
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    halt_follow_a: assert property (halt_err_in |=> halt_req_out)
        else $error("halt request missing");
    halt_vector_a: assert property (halt_req_out |-> vector_out == 8'h00)
        else $error("halt not ranked first");
    mchk_cause_a: assert property (instr_boundary_in && mmgt_fault_in && !halt_err_in
        |=> mchk_out && vector_out == 8'h04)
        else $error("machine check missing");
    mchk_pulse_a: assert property (mchk_out |=> !mchk_out)
        else $error("machine check too long");
    frame_pc_a: assert property (mchk_out |-> frame_pc_out == $past(cur_pc_in))
        else $error("frame PC wrong");
    hard_write_a: assert property (op_write_in && tag_parity_error_in |=> hard_int_out)
        else $error("hard interrupt missing");
    soft_fill_a: assert property (!op_write_in && fill_valid_in && fill_ecc_ce_in
        |=> soft_int_out)
        else $error("soft interrupt missing");
    soft_pcache_a: assert property (pcache_parity_in |=> soft_int_out)
        else $error("soft interrupt missing");
    bus_hard_a: assert property (bus_hard_error_in |=> hard_int_out)
        else $error("bus hard interrupt missing");
    ext_level_a: assert property (ext_error_in [*5] |=> hard_int_out)
        else $error("external error not pending");
    rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data outside slot");

    mchk_c: cover property (mchk_out);
    halt_c: cover property (halt_req_out);
    ext_c: cover property (hard_int_out && ext_error_in);
endmodule // enc_error_chk

bind enc_error_unit enc_error_chk chk (.*);

// *** tb/error_notification_capture_bench.sv ***
// Self-checking bench for the error notification and capture block
`timescale 1ns/1ps
`include "enc_defines.vh"
module error_notification_capture_bench;
    logic        core_clk_in, rst_in, reg_wr_in, reg_rd_in, op_write_in, instr_boundary_in;
    logic        ext_error_in, dirty_wr_in, dirty_val_in;
    logic [3:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, access_addr_in, fill_addr_in, cur_pc_in, cur_psl_in;
    logic [7:0]  fill_syndrome_in, dirty_idx_in;
    logic [19:0] cache_tag_in;
    logic [15:0] ev;
    wire         halt_err_in, mmgt_fault_in, ucode_fault_in, stall_timeout_in, tb_parity_in;
    wire         icache_parity_in, pcache_parity_in, tag_parity_error_in, ack_hard_error_in;
    wire         tag_control_parity_error_in, bus_soft_error_in, bus_hard_error_in;
    wire         fill_valid_in, fill_ecc_ue_in, fill_ecc_ce_in, fill_parity_error_in;
    wire [31:0]  reg_rdata_out, halt_pc_out, frame_pc_out, frame_psl_out, frame_info_out;
    wire         halt_req_out, mchk_out, hard_int_out, soft_int_out, arb_error_out;
    wire         fill_hard_err_out;
    wire [7:0]   vector_out;
    int          bad_count, compares, i;
    logic [15:0] mc [4] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800};

    assign {halt_err_in, mmgt_fault_in, ucode_fault_in, stall_timeout_in, tb_parity_in,
            icache_parity_in, pcache_parity_in, tag_parity_error_in,
            tag_control_parity_error_in, ack_hard_error_in, bus_soft_error_in,
            bus_hard_error_in, fill_valid_in, fill_ecc_ue_in, fill_ecc_ce_in,
            fill_parity_error_in} = ev;

    enc_error_unit dut (.*);

    initial
    begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end

    task check(input string n, input [31:0] seen, input [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task conclude;
        $display("Compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task wr(input [3:0] a, input [31:0] d);
        @(posedge core_clk_in);
        reg_wr_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task rd(input [3:0] a, input [31:0] exp, input string n);
        @(posedge core_clk_in);
        reg_rd_in <= 1'b1; reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 check(n, reg_rdata_out, exp);
    endtask

    // One-cycle error event, outputs settled just after the answering edge
    task fire(input [15:0] e);
        @(posedge core_clk_in);
        ev <= e;
        @(posedge core_clk_in);
        ev <= 16'h0;
        #1;
    endtask

    task wait_hard(input logic v);
        for (i = 0; i < 10 && hard_int_out !== v; i++)
        begin
            @(posedge core_clk_in);
            #1;
        end
        if (hard_int_out !== v)
        begin
            bad_count++;
            conclude();
        end
    endtask

    initial
    begin
        rst_in = 1'b1;
        {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, ev} = 54'h0;
        {op_write_in, instr_boundary_in, ext_error_in, dirty_wr_in, dirty_val_in} = 5'h0;
        {access_addr_in, fill_addr_in, cur_pc_in, cur_psl_in} = 128'h0;
        {fill_syndrome_in, dirty_idx_in, cache_tag_in} = 36'h0;
        repeat (5) @(posedge core_clk_in);
        rst_in <= 1'b0;
        rd(`ENC_ADDR_STATUS, 32'h0, "status");
        check("hard", hard_int_out, 1'b0);
        instr_boundary_in <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            cur_pc_in <= 32'h1000 + k;
            cur_psl_in <= 32'h0400 + k;
            fire(mc[k]);
            check("mchk", mchk_out, 1'b1);
            check("vec", vector_out, `ENC_VEC_MCHK);
            check("fpc", frame_pc_out, 32'h1000 + k);
            check("fpsl", frame_psl_out, 32'h0400 + k);
        end
        wr(`ENC_ADDR_HALT_TGT, 32'h0000_2468);
        rd(`ENC_ADDR_HALT_TGT, 32'h0000_2468, "tgt");
        fire(16'hC000);
        check("halt", halt_req_out, 1'b1);
        check("hpc", halt_pc_out, 32'h0000_2468);
        check("hvec", vector_out, `ENC_VEC_NONE);
        instr_boundary_in <= 1'b0;
        fire(16'h0200);
        check("soft", soft_int_out, 1'b1);
        check("svec", vector_out, `ENC_VEC_SOFT);
        fill_addr_in <= 32'h0000_ABC8; fill_syndrome_in <= 8'h5A; cache_tag_in <= 20'hABCDE;
        fire(16'h000A);
        check("fsoft", soft_int_out, 1'b1);
        rd(`ENC_ADDR_FILL_ADDR, 32'h0000_ABC8, "faddr");
        rd(`ENC_ADDR_SYNDROME, 32'h0000_005A, "synd");
        rd(`ENC_ADDR_TAG, 32'h000A_BCDE, "tag");
        rd(`ENC_ADDR_STATUS, 32'h20, "fstat");
        wr(`ENC_ADDR_STATUS, 32'h20);
        rd(`ENC_ADDR_STATUS, 32'h0, "clr");
        check("sclr", soft_int_out, 1'b0);
        op_write_in <= 1'b1; access_addr_in <= 32'h0000_1110;
        fire(16'h0010);
        check("hvec", vector_out, `ENC_VEC_HARD);
        access_addr_in <= 32'h0000_2220;
        fire(16'h0100);
        check("hard", hard_int_out, 1'b1);
        rd(`ENC_ADDR_BUS_ADDR, 32'h0000_1110, "baddr");
        rd(`ENC_ADDR_STATUS, 32'h81, "ovf");
        wr(`ENC_ADDR_STATUS, 32'h0);
        rd(`ENC_ADDR_STATUS, 32'h81, "w0");
        check("hlvl", hard_int_out, 1'b1);
        wr(`ENC_ADDR_STATUS, 32'h81);
        rd(`ENC_ADDR_STATUS, 32'h0, "w1");
        check("hclr", hard_int_out, 1'b0);
        fire(16'h0040);
        rd(`ENC_ADDR_STATUS, 32'h10, "ack");
        check("alvl", hard_int_out, 1'b1);
        wr(`ENC_ADDR_STATUS, 32'h10);
        rd(`ENC_ADDR_STATUS, 32'h0, "aclr");
        check("aoff", hard_int_out, 1'b0);
        ext_error_in <= 1'b1;
        wait_hard(1'b1);
        check("ext", hard_int_out, 1'b1);
        ext_error_in <= 1'b0;
        wait_hard(1'b0);
        op_write_in <= 1'b0;
        fire(16'h0080);
        check("tsoft", soft_int_out, 1'b1);
        check("arb", arb_error_out, 1'b1);
        wr(`ENC_ADDR_STATUS, 32'hFF);
        fire(16'h000C);
        check("nomchk", mchk_out, 1'b0);
        check("fhe", fill_hard_err_out, 1'b1);
        instr_boundary_in <= 1'b1;
        @(posedge core_clk_in);
        #1 check("pmchk", mchk_out, 1'b1);
        check("pvec", vector_out, `ENC_VEC_MCHK);
        check("finfo", frame_info_out, 32'h20);
        instr_boundary_in <= 1'b0;
        @(posedge core_clk_in);
        dirty_wr_in <= 1'b1; dirty_idx_in <= 8'h05; dirty_val_in <= 1'b1;
        @(posedge core_clk_in);
        dirty_wr_in <= 1'b0;
        wr(`ENC_ADDR_DIRTY_IX, 32'h5);
        rd(`ENC_ADDR_DIRTY_IX, 32'h5, "dix");
        rd(`ENC_ADDR_DIRTY, 32'h1, "dirty");
        rd(4'hF, 32'h0, "unmap");
        fire(16'h0010);
        rst_in <= 1'b1;
        @(posedge core_clk_in);
        rst_in <= 1'b0;
        rd(`ENC_ADDR_STATUS, 32'h0, "rst");
        check("rhard", hard_int_out, 1'b0);
        conclude();
    end
endmodule // error_notification_capture_bench
